//--- pkg/adc_cfg_pkg.sv
package adc_cfg_pkg;

  // ----------------------------------------------------------------
  // Serial frame layout
  // ----------------------------------------------------------------
  localparam int unsigned     FRAME_BITS  = 16;
  localparam int unsigned     HDR_BITS    = 8;
  localparam logic [4:0]      CNT_HDR     = 5'h07;
  localparam logic [4:0]      CNT_LAST    = 5'h0f;
  localparam logic [4:0]      CNT_FULL    = 5'h10;
  localparam int unsigned     RW_BIT      = 7;

  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [6:0] OFS_SOFT_RESET_CTL       = 7'h00;
  localparam logic [6:0] OFS_POWER_DOWN_CTL       = 7'h01;
  localparam logic [6:0] OFS_CONVERTER_CTL        = 7'h02;
  localparam logic [6:0] OFS_LINK_DEVICE_IDENT    = 7'h03;
  localparam logic [6:0] OFS_LINK_BANK_IDENT      = 7'h04;
  localparam logic [6:0] OFS_LANE_COUNT_M1        = 7'h05;
  localparam logic [6:0] OFS_MULTIFRAME_LEN_M1    = 7'h06;
  localparam logic [6:0] OFS_LINK_MODE_CTL        = 7'h07;
  localparam logic [6:0] OFS_LINK_SUBCLASS_CTL    = 7'h08;
  localparam logic [6:0] OFS_TEST_PATTERN_SELECT  = 7'h09;
  localparam logic [6:0] OFS_OUTPUT_SWING_CTL     = 7'h0a;
  localparam int unsigned NUM_REGS                = 11;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int unsigned SOFT_RESET_BIT   = 7;
  localparam int unsigned SLEEP_BIT        = 3;
  localparam int unsigned NAP_BIT          = 2;
  localparam int unsigned CHAN_B_OFF_BIT   = 1;
  localparam int unsigned CHAN_A_OFF_BIT   = 0;
  localparam int unsigned CLK_HALVING_BIT  = 2;
  localparam int unsigned OVF_EN_BIT       = 1;
  localparam int unsigned DUTY_STAB_BIT    = 0;
  localparam logic [7:0]  WO_READ_VALUE    = 8'hff;
  localparam logic [7:0]  UNMAPPED_READ    = 8'h00;

  // Writable bits per register, index 0 unused (write-only strobe)
  localparam logic [7:0] REG_MASK [NUM_REGS] = '{
    8'h00, 8'h0f, 8'h07, 8'hff, 8'h0f, 8'h07, 8'h1f, 8'h3b, 8'hff, 8'h07, 8'h03
  };

  // Reset values
  localparam logic [7:0] REG_DEFAULT [NUM_REGS] = '{
    8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h01, 8'h0f, 8'h00, 8'h00, 8'h00, 8'h00
  };

  // ----------------------------------------------------------------
  // Lane output pattern selections
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    PATTERN_NORMAL_DATA  = 3'h0,
    PATTERN_K28_5        = 3'h1,
    PATTERN_K28_7        = 3'h2,
    PATTERN_D21_5        = 3'h3,
    PATTERN_PRBS15       = 3'h4,
    PATTERN_LANE_ALIGN   = 3'h5,
    PATTERN_TEST_SAMPLES = 3'h6,
    PATTERN_MOD_RPAT     = 3'h7
  } pattern_e;

endpackage

//--- core/spi_frame_rx.sv
`timescale 1ns/100ps

module spi_frame_rx (
  input  wire logic        sys_clk,
  input  wire logic        rst,
  input  wire logic        spi_cs_n,
  input  wire logic        spi_sck,
  input  wire logic        spi_sdi,
  input  wire logic [7:0]  rd_data,
  output logic             hdr_pulse,
  output logic             cmd_pulse,
  output logic [15:0]      frame_word,
  output logic             spi_sdo_oe
);
  import adc_cfg_pkg::*;

  // ----------------------------------------------------------------
  // Frame capture
  // ----------------------------------------------------------------
  logic        sck_prev_reg, sck_prev_next;
  logic [4:0]  cnt_reg,      cnt_next;
  logic [15:0] shift_reg,    shift_next;
  logic        hdr_reg,      hdr_next;
  logic        cmd_reg,      cmd_next;
  logic [7:0]  sdo_reg,      sdo_next;
  logic        sdo_act_reg,  sdo_act_next;
  logic        oe_reg,       oe_next;
  logic        rise;
  logic        fall;

  assign rise = spi_sck & ~sck_prev_reg & ~spi_cs_n;
  assign fall = ~spi_sck & sck_prev_reg & ~spi_cs_n;

  always_comb begin
    sck_prev_next = spi_sck;
    cnt_next      = cnt_reg;
    shift_next    = shift_reg;
    hdr_next      = 1'b0;
    cmd_next      = 1'b0;
    sdo_next      = sdo_reg;
    sdo_act_next  = sdo_act_reg;
    if (spi_cs_n) begin
      cnt_next     = '0;
      sdo_act_next = 1'b0;
    end else if (rise && cnt_reg != CNT_FULL) begin // RQ8
      cnt_next   = cnt_reg + 5'h01;
      shift_next = {shift_reg[14:0], spi_sdi};
      hdr_next   = (cnt_reg == CNT_HDR);
      cmd_next   = (cnt_reg == CNT_LAST);
    end
    // Header just landed: load readback, first bit out before next rise
    if (hdr_reg && shift_reg[RW_BIT]) begin // RQ9
      sdo_next     = rd_data;
      sdo_act_next = 1'b1;
    end else if (fall && sdo_act_reg && cnt_reg > 5'(HDR_BITS)) begin
      sdo_next = {sdo_reg[6:0], 1'b1};
    end
    // Open drain: only ever pull low
    oe_next = sdo_act_next & ~sdo_next[7];
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      sck_prev_reg <= 1'b0;
      cnt_reg      <= '0;
      shift_reg    <= '0;
      hdr_reg      <= 1'b0;
      cmd_reg      <= 1'b0;
      sdo_reg      <= 8'hff;
      sdo_act_reg  <= 1'b0;
      oe_reg       <= 1'b0;
    end else begin
      sck_prev_reg <= sck_prev_next;
      cnt_reg      <= cnt_next;
      shift_reg    <= shift_next;
      hdr_reg      <= hdr_next;
      cmd_reg      <= cmd_next;
      sdo_reg      <= sdo_next;
      sdo_act_reg  <= sdo_act_next;
      oe_reg       <= oe_next;
    end
  end

  assign hdr_pulse  = hdr_reg;
  assign cmd_pulse  = cmd_reg;
  assign frame_word = shift_reg;
  assign spi_sdo_oe = oe_reg;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  a_frame_sixteen: assert property (@(posedge sys_clk) disable iff (rst) // RQ8
    cmd_reg |-> cnt_reg == CNT_FULL)
    else $error("command taken before sixteen edges");
  a_extra_edges_ignored: assert property (@(posedge sys_clk) disable iff (rst) // RQ8
    (cnt_reg == CNT_FULL && !spi_cs_n) |=> $stable(shift_reg) && !cmd_reg)
    else $error("edge after sixteenth changed frame");

endmodule

//--- core/adc_serial_config_regs.sv
`timescale 1ns/100ps

// What this block does
// [RQ1] Writing reg0 bit7 restores defaults, self-clears
// [RQ2] Reset register reads back all ones
// [RQ3] Reg1 bits: sleep, nap, B off, A off
// [RQ4] Nap and channel power-downs default zero
// [RQ5] Reg2 bit2 halves input clock rate
// [RQ6] Minus-one fields used as value plus one
// [RQ7] Reg9 three-bit field selects lane pattern
// [RQ8] Chip-select framed sixteen-bit word, extras ignored
// [RQ9] Read shifts register out, leaves it unchanged
// [RQ10] Unused bits ignore writes, read zero
module adc_serial_config_regs (
  input  wire logic                   sys_clk,
  input  wire logic                   rst,
  input  wire logic                   spi_cs_n,
  input  wire logic                   spi_sck,
  input  wire logic                   spi_sdi,
  output logic                        spi_sdo_out,
  output logic                        spi_sdo_oe,
  input  wire logic                   device_clock_in,
  output logic                        sample_strobe,
  output logic                        soft_reset_active,
  output logic                        converter_sleep,
  output logic                        both_chan_nap,
  output logic                        chan_b_power_off,
  output logic                        chan_a_power_off,
  output logic                        clock_halving_sel,
  output logic                        overflow_out_en,
  output logic                        duty_stab_en,
  output logic [7:0]                  device_ident,
  output logic [3:0]                  bank_ident,
  output logic [3:0]                  lane_count,
  output logic [5:0]                  frames_per_multiframe,
  output logic [7:0]                  link_mode,
  output logic [7:0]                  subclass_mode,
  output logic [2:0]                  pattern_select_field,
  output adc_cfg_pkg::pattern_e       pattern_mode,
  output logic [1:0]                  output_swing
);
  import adc_cfg_pkg::*;

  // ----------------------------------------------------------------
  // Serial front end
  // ----------------------------------------------------------------
  logic        hdr_pulse;
  logic        cmd_pulse;
  logic [15:0] frame_word;
  logic [7:0]  rd_data;
  logic [6:0]  frame_addr;
  logic        frame_rw;
  logic [7:0]  frame_data;
  logic        wr_cmd;

  spi_frame_rx u_rx (
    .sys_clk    (sys_clk),
    .rst        (rst),
    .spi_cs_n   (spi_cs_n),
    .spi_sck    (spi_sck),
    .spi_sdi    (spi_sdi),
    .rd_data    (rd_data),
    .hdr_pulse  (hdr_pulse),
    .cmd_pulse  (cmd_pulse),
    .frame_word (frame_word),
    .spi_sdo_oe (spi_sdo_oe)
  );

  // Open drain: the level driven is always low
  assign spi_sdo_out = 1'b0;

  // During the header pulse the address sits in the low bits
  assign frame_rw   = hdr_pulse ? frame_word[RW_BIT] : frame_word[15];
  assign frame_addr = hdr_pulse ? frame_word[6:0] : frame_word[14:8];
  assign frame_data = frame_word[7:0];
  assign wr_cmd     = cmd_pulse & ~frame_rw; // RQ9

  // ----------------------------------------------------------------
  // Register file
  // ----------------------------------------------------------------
  logic [NUM_REGS-1:1][7:0] reg_file_reg, reg_file_next;
  logic                     soft_rst_reg, soft_rst_next;

  // Strobe lives one cycle, then the bank reloads and it drops
  always_comb begin
    soft_rst_next = wr_cmd && frame_addr == OFS_SOFT_RESET_CTL
                    && frame_data[SOFT_RESET_BIT]; // RQ1
  end

  genvar gi;
  generate
    for (gi = 1; gi < NUM_REGS; gi++) begin : g_reg
      always_comb begin
        if (soft_rst_reg) begin
          reg_file_next[gi] = REG_DEFAULT[gi]; // RQ1 RQ4
        end else if (wr_cmd && frame_addr == 7'(gi)) begin
          reg_file_next[gi] = frame_data & REG_MASK[gi]; // RQ10
        end else begin
          reg_file_next[gi] = reg_file_reg[gi];
        end
      end
    end
  endgenerate

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      soft_rst_reg <= 1'b0;
      for (int i = 1; i < NUM_REGS; i++) begin
        reg_file_reg[i] <= REG_DEFAULT[i];
      end
    end else begin
      soft_rst_reg <= soft_rst_next;
      reg_file_reg <= reg_file_next;
    end
  end

  // Readback mux, looked up in the header cycle
  always_comb begin
    if (frame_addr == OFS_SOFT_RESET_CTL) begin
      rd_data = WO_READ_VALUE; // RQ2
    end else if (frame_addr < 7'(NUM_REGS)) begin
      rd_data = reg_file_reg[frame_addr[3:0]];
    end else begin
      rd_data = UNMAPPED_READ;
    end
  end

  // ----------------------------------------------------------------
  // Sample rate from the device clock
  // ----------------------------------------------------------------
  logic dclk_prev_reg, dclk_prev_next;
  logic phase_reg,     phase_next;
  logic strobe_reg,    strobe_next;
  logic dclk_tick;

  assign dclk_tick = device_clock_in & ~dclk_prev_reg;

  always_comb begin
    dclk_prev_next = device_clock_in;
    phase_next     = phase_reg;
    strobe_next    = 1'b0;
    if (!clock_halving_sel) begin
      phase_next  = 1'b0;
      strobe_next = dclk_tick; // RQ5
    end else if (dclk_tick) begin
      phase_next  = ~phase_reg;
      strobe_next = phase_reg; // RQ5
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      dclk_prev_reg <= 1'b0;
      phase_reg     <= 1'b0;
      strobe_reg    <= 1'b0;
    end else begin
      dclk_prev_reg <= dclk_prev_next;
      phase_reg     <= phase_next;
      strobe_reg    <= strobe_next;
    end
  end

  // ----------------------------------------------------------------
  // Decoded controls
  // ----------------------------------------------------------------
  assign sample_strobe         = strobe_reg;
  assign soft_reset_active     = soft_rst_reg;
  assign converter_sleep       = reg_file_reg[1][SLEEP_BIT]; // RQ3
  assign both_chan_nap         = reg_file_reg[1][NAP_BIT]; // RQ3
  assign chan_b_power_off      = reg_file_reg[1][CHAN_B_OFF_BIT]; // RQ3
  assign chan_a_power_off      = reg_file_reg[1][CHAN_A_OFF_BIT]; // RQ3
  assign clock_halving_sel     = reg_file_reg[2][CLK_HALVING_BIT];
  assign overflow_out_en       = reg_file_reg[2][OVF_EN_BIT];
  assign duty_stab_en          = reg_file_reg[2][DUTY_STAB_BIT];
  assign device_ident          = reg_file_reg[3];
  assign bank_ident            = reg_file_reg[4][3:0];
  assign lane_count            = {1'b0, reg_file_reg[5][2:0]} + 4'h1; // RQ6
  assign frames_per_multiframe = {1'b0, reg_file_reg[6][4:0]} + 6'h01; // RQ6
  assign link_mode             = reg_file_reg[7];
  assign subclass_mode         = reg_file_reg[8];
  assign pattern_select_field  = reg_file_reg[9][2:0];
  assign pattern_mode          = pattern_e'(reg_file_reg[9][2:0]); // RQ7
  assign output_swing          = reg_file_reg[10][1:0];

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  a_soft_reset_start: assert property (@(posedge sys_clk) disable iff (rst) // RQ1
    (wr_cmd && frame_addr == OFS_SOFT_RESET_CTL && frame_data[7]) |=> soft_rst_reg)
    else $error("soft reset not started");
  a_soft_reset_done: assert property (@(posedge sys_clk) disable iff (rst) // RQ1
    soft_rst_reg |=> !soft_rst_reg && lane_count == 4'h2
      && frames_per_multiframe == 6'h10 && !chan_a_power_off)
    else $error("defaults not restored or bit stuck");
  a_wo_reads_ones: assert property (@(posedge sys_clk) disable iff (rst) // RQ2
    (hdr_pulse && frame_addr == OFS_SOFT_RESET_CTL)
      |-> rd_data == WO_READ_VALUE ##1 !spi_sdo_oe)
    else $error("reset register readback not all ones");
  a_power_write: assert property (@(posedge sys_clk) disable iff (rst) // RQ3
    (wr_cmd && frame_addr == OFS_POWER_DOWN_CTL) |=>
      {converter_sleep, both_chan_nap, chan_b_power_off, chan_a_power_off}
        == $past(frame_data[3:0]))
    else $error("power controls do not follow write");
  a_halving_strobe: assert property (@(posedge sys_clk) disable iff (rst) // RQ5
    (clock_halving_sel && $past(clock_halving_sel) && dclk_tick && !phase_reg)
      |=> !sample_strobe)
    else $error("halved clock strobed on every edge");
  a_lane_plus_one: assert property (@(posedge sys_clk) disable iff (rst) // RQ6
    (wr_cmd && frame_addr == OFS_LANE_COUNT_M1) |=>
      lane_count == {1'b0, $past(frame_data[2:0])} + 4'h1)
    else $error("lane count not stored plus one");
  a_pattern_write: assert property (@(posedge sys_clk) disable iff (rst) // RQ7
    (wr_cmd && frame_addr == OFS_TEST_PATTERN_SELECT) |=>
      pattern_mode == pattern_e'($past(frame_data[2:0])))
    else $error("pattern select not updated");
  a_read_no_update: assert property (@(posedge sys_clk) disable iff (rst) // RQ9
    (cmd_pulse && frame_rw && !soft_rst_reg) |=> $stable(reg_file_reg))
    else $error("read changed a register");
  a_unused_zero: assert property (@(posedge sys_clk) disable iff (rst) // RQ10
    reg_file_reg[4][7:4] == 4'h0 && reg_file_reg[6][7:5] == 3'h0
      && reg_file_reg[7][2] == 1'b0)
    else $error("unused bit set");

  c_write: cover property (@(posedge sys_clk) disable iff (rst) wr_cmd);
  c_read: cover property (@(posedge sys_clk) disable iff (rst) hdr_pulse && frame_rw);
  c_soft_reset: cover property (@(posedge sys_clk) disable iff (rst) soft_rst_reg);
  c_halved: cover property (@(posedge sys_clk) disable iff (rst)
    clock_halving_sel && sample_strobe);

endmodule

//--- tb/spi_host_model.sv
`timescale 1ns/100ps

module spi_host_model (
  input  wire logic sys_clk,
  output logic      spi_cs_n,
  output logic      spi_sck,
  output logic      spi_sdi,
  input  wire logic spi_sdo_out,
  input  wire logic spi_sdo_oe
);
  // ----------------------------------------
  // Open-drain readback line
  // ----------------------------------------
  // Pull-up wins whenever the device lets go
  logic sdo_wire;
  assign sdo_wire = spi_sdo_oe ? spi_sdo_out : 1'b1;

  initial begin
    spi_cs_n = 1'b1;
    spi_sck  = 1'b0;
    spi_sdi  = 1'b0;
  end

  // ----------------------------------------
  // One framed transfer
  // ----------------------------------------
  // Phases of ph cycles; clock idles low, sdi inverted once released
  task automatic xfer(input logic [15:0] w, input int nbits, input int ph,
                      output logic [7:0] rd);
    rd = 8'h00;
    @(negedge sys_clk);
    spi_cs_n = 1'b0;
    for (int i = 0; i < nbits; i++) begin
      spi_sdi = (i < 16) ? w[15-i] : 1'($urandom);
      repeat (ph) @(negedge sys_clk);
      spi_sck = 1'b1;
      if (i >= 8 && i < 16) begin
        rd = {rd[6:0], sdo_wire};
      end
      repeat (ph) @(negedge sys_clk);
      spi_sck = 1'b0;
    end
    repeat (ph) @(negedge sys_clk);
    spi_cs_n = 1'b1;
    spi_sdi  = ~spi_sdi;
    repeat (3) @(negedge sys_clk);
  endtask
endmodule

//--- tb/tb_adc_serial_config_regs.sv
`timescale 1ns/100ps

module tb_adc_serial_config_regs;
  import adc_cfg_pkg::*;
  logic       sys_clk, rst, spi_cs_n, spi_sck, spi_sdi, spi_sdo_out, spi_sdo_oe;
  logic       device_clock_in, sample_strobe, soft_reset_active;
  logic       converter_sleep, both_chan_nap, chan_b_power_off, chan_a_power_off;
  logic       clock_halving_sel, overflow_out_en, duty_stab_en;
  logic [7:0] device_ident, link_mode, subclass_mode, rd, d;
  logic [3:0] bank_ident, lane_count;
  logic [5:0] frames_per_multiframe;
  logic [2:0] pattern_select_field;
  logic [1:0] output_swing;
  logic [6:0] a;
  pattern_e   pattern_mode;
  int         mdl [NUM_REGS];
  int         err_count, total_checks, scnt, rcnt;
  pattern_e   pats [8] = '{PATTERN_NORMAL_DATA, PATTERN_K28_5, PATTERN_K28_7,
                           PATTERN_D21_5, PATTERN_PRBS15, PATTERN_LANE_ALIGN,
                           PATTERN_TEST_SAMPLES, PATTERN_MOD_RPAT};

  adc_serial_config_regs dut (.sys_clk(sys_clk), .rst(rst), .spi_cs_n(spi_cs_n),
    .spi_sck(spi_sck), .spi_sdi(spi_sdi), .spi_sdo_out(spi_sdo_out),
    .spi_sdo_oe(spi_sdo_oe), .device_clock_in(device_clock_in),
    .sample_strobe(sample_strobe), .soft_reset_active(soft_reset_active),
    .converter_sleep(converter_sleep), .both_chan_nap(both_chan_nap),
    .chan_b_power_off(chan_b_power_off), .chan_a_power_off(chan_a_power_off),
    .clock_halving_sel(clock_halving_sel), .overflow_out_en(overflow_out_en),
    .duty_stab_en(duty_stab_en), .device_ident(device_ident), .bank_ident(bank_ident),
    .lane_count(lane_count), .frames_per_multiframe(frames_per_multiframe),
    .link_mode(link_mode), .subclass_mode(subclass_mode),
    .pattern_select_field(pattern_select_field), .pattern_mode(pattern_mode),
    .output_swing(output_swing));

  spi_host_model host (.sys_clk(sys_clk), .spi_cs_n(spi_cs_n), .spi_sck(spi_sck),
    .spi_sdi(spi_sdi), .spi_sdo_out(spi_sdo_out), .spi_sdo_oe(spi_sdo_oe));

  // ----------------------------------------
  // Checking and bus helpers
  // ----------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic stop_test();
    $display("Checks %0d, mismatches %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  // Only whole frames change the model
  task automatic wr(input logic [6:0] ad, input logic [7:0] dd, input int n);
    host.xfer({1'b0, ad, dd}, n, $urandom_range(6, 3), rd);
    if (n >= 16 && ad >= 7'h01 && ad <= 7'h0a) begin
      mdl[ad] = dd & REG_MASK[ad];
    end
    if (n >= 16 && ad == 7'h00 && dd[7]) begin
      for (int i = 0; i < NUM_REGS; i++) mdl[i] = REG_DEFAULT[i];
    end
  endtask

  // Random data on sdi during reads must be ignored
  task automatic rdchk(input logic [6:0] ad);
    int e;
    e = (ad == 7'h00) ? 255 : (ad < 7'h0b) ? mdl[ad] : 0;
    host.xfer({1'b1, ad, 8'($urandom)}, 16, $urandom_range(6, 3), rd);
    check(32'(rd), e);
    check(32'(spi_sdo_oe), 0);
  endtask

  task automatic outs();
    check(32'({converter_sleep, both_chan_nap, chan_b_power_off, chan_a_power_off}),
          mdl[1]);
    check(32'({clock_halving_sel, overflow_out_en, duty_stab_en}), mdl[2]);
    check(32'({bank_ident, device_ident}), (mdl[4] << 8) | mdl[3]);
    check(32'(lane_count), mdl[5] + 1);
    check(32'(frames_per_multiframe), mdl[6] + 1);
    check(32'({link_mode, subclass_mode}), (mdl[7] << 8) | mdl[8]);
    check(32'({pattern_select_field, output_swing}), (mdl[9] << 2) | mdl[10]);
  endtask

  always @(posedge sys_clk) begin
    if (sample_strobe === 1'b1) scnt++;
    if (soft_reset_active === 1'b1) rcnt++;
  end

  // ----------------------------------------
  // Clock, watchdog, main sequence
  // ----------------------------------------
  initial begin
    sys_clk = 1'b0;
    forever #4 sys_clk = ~sys_clk;
  end

  // Roughly five times the expected run
  initial begin
    #600_000;
    err_count++;
    stop_test();
  end

  initial begin
    void'($urandom(32'h0467ac7b));
    rst = 1'b1;
    device_clock_in = 1'b0;
    for (int i = 0; i < NUM_REGS; i++) mdl[i] = REG_DEFAULT[i];
    repeat (16) @(negedge sys_clk);
    rst = 1'b0;
    for (int i = 0; i < 13; i++) rdchk(7'(i));
    outs();
    repeat (30) begin
      a = 7'($urandom_range(10, 1));
      d = 8'($urandom);
      wr(a, d, 16);
      rdchk(a);
      outs();
    end
    wr(7'h0b, 8'hff, 16);
    wr(7'h7f, 8'hff, 16);
    outs();
    wr(7'h01, ~8'(mdl[1]), 12);
    rdchk(7'h01);
    wr(7'h02, ~8'(mdl[2]), 20);
    rdchk(7'h02);
    for (int i = 0; i < 8; i++) begin
      wr(7'h09, 8'hf8 | 8'(i), 16);
      check(32'(pattern_mode), 32'(pats[i]));
    end
    // Even tick count makes the halved result phase independent
    for (int h = 0; h < 2; h++) begin
      wr(7'h02, 8'(h << 2), 16);
      scnt = 0;
      repeat (8) begin
        device_clock_in = 1'b1;
        repeat (2) @(negedge sys_clk);
        device_clock_in = 1'b0;
        repeat (2) @(negedge sys_clk);
      end
      repeat (6) @(negedge sys_clk);
      check(scnt, h ? 4 : 8);
    end
    rcnt = 0;
    wr(7'h00, 8'h80, 16);
    check(rcnt, 1);
    outs();
    wr(7'h05, 8'h06, 16);
    wr(7'h00, 8'h7f, 16);
    check(rcnt, 1);
    rdchk(7'h05);
    rdchk(7'h00);
    stop_test();
  end
endmodule
